// ===== verilog/thep_cfg.svh
// constants of the transmit errored-packet insertion and performance counter block
`ifndef THEP_CFG_SVH
`define THEP_CFG_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define THEP_IDX_CTRL_LOW 10'h0c4
`define THEP_IDX_COUNT_CTRL 10'h0c6
`define THEP_IDX_RATE_CTRL 10'h0c7
`define THEP_IDX_STATUS 10'h0c8
`define THEP_IDX_STATUS_LATCHED 10'h0c9
`define THEP_IDX_IRQ_ENABLE 10'h0ca
`define THEP_IDX_PKT_CNT0 10'h0cc
`define THEP_IDX_PKT_CNT1 10'h0cd
`define THEP_IDX_PKT_CNT2 10'h0ce
`define THEP_IDX_BYTE_CNT0 10'h0d0
`define THEP_IDX_BYTE_CNT1 10'h0d1
`define THEP_IDX_BYTE_CNT2 10'h0d2
`define THEP_IDX_BYTE_CNT3 10'h0d3
`define THEP_IDX_MON_UPDATE 10'h0d6
`define THEP_IDX_MON_STATUS 10'h0d7

// ************************************************************
// field positions and codes
// ************************************************************
`define THEP_BIT_INITIATE 0
`define THEP_BIT_FINISHED 0
`define THEP_BIT_IRQ_EN 0
`define THEP_BIT_MON_UPDATE 0
`define THEP_BIT_MON_STATUS 0
`define THEP_CTRL_LOW_MASK 8'h3e
`define THEP_RATE_MASK 8'h7f
`define THEP_TOTAL_CONTINUOUS 8'hff
`define THEP_RATE_Y_MAX 3'h6

// ************************************************************
// reset values and widths
// ************************************************************
`define THEP_RST_BYTE 8'h00
`define THEP_PKT_CNT_W 24
`define THEP_BYTE_CNT_W 32
`define THEP_PERIOD_W 24

`endif

// ===== verilog/thep_pkg.sv
// types of the transmit errored-packet insertion block
package thep_pkg;

   typedef enum logic [1:0]
   {
      THEP_IDLE = 2'b00,
      THEP_RUN = 2'b01,
      THEP_DONE = 2'b10
   } thep_state_t;

endpackage

// ===== verilog/thep_pm_counter.sv
// running performance counter with a snapshot register for software
`timescale 1ns/100ps
`include "thep_cfg.svh"

module thep_pm_counter #(
   parameter int W = 24
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // events
   input wire logic inc,
   input wire logic update,
   // snapshot
   output logic [W-1:0] shown
);

   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic [W-1:0] next_shown;

   // an event in the update cycle belongs to the new period, so restart at one
   always_comb
   begin
      next_cnt = cnt + {{(W-1){1'b0}}, inc};
      next_shown = shown;
      if (update)
      begin
         next_shown = cnt;
         next_cnt = {{(W-1){1'b0}}, inc};
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cnt <= '0;
         shown <= '0;
      end
      else
      begin
         cnt <= next_cnt;
         shown <= next_shown;
      end
   end

endmodule // thep_pm_counter

// ===== verilog/thep_rate_divider.sv
// counts packets and marks every period-th one
`timescale 1ns/100ps
`include "thep_cfg.svh"

module thep_rate_divider (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic clear,
   input wire logic step,
   input wire logic [`THEP_PERIOD_W-1:0] period,
   // result
   output logic hit
);

   logic [`THEP_PERIOD_W-1:0] cnt;
   logic [`THEP_PERIOD_W-1:0] next_cnt;

   // a period of zero never hits, which disables insertion
   assign hit = step && (period != '0) && (cnt == period - `THEP_PERIOD_W'(1));

   always_comb
   begin
      next_cnt = cnt;
      if (clear || hit)
         next_cnt = '0;
      else if (step)
         next_cnt = cnt + `THEP_PERIOD_W'(1);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         cnt <= '0;
      else
         cnt <= next_cnt;
   end

endmodule // thep_rate_divider

// ===== verilog/thep_top.sv
// transmit errored-packet insertion and transmit performance counters, APB slave
`timescale 1ns/100ps
`include "thep_cfg.svh"

module thep_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // transmit datapath
   input wire logic tx_pkt_start,
   input wire logic tx_byte_sent,
   output logic tx_pkt_errored,
   // interrupt
   output logic irq
);

   // ************************************************************
   // register state
   // ************************************************************
   logic [7:0] ctrl_low;
   logic [7:0] count_ctrl;
   logic [7:0] rate_ctrl;
   logic [7:0] irq_enable;
   logic [7:0] mon_update;
   logic initiate_armed;
   logic finished;
   logic finished_latched;
   logic finished_prev;
   logic mon_status;
   logic mon_update_prev;
   logic [7:0] next_ctrl_low;
   logic [7:0] next_count_ctrl;
   logic [7:0] next_rate_ctrl;
   logic [7:0] next_irq_enable;
   logic [7:0] next_mon_update;
   logic next_initiate_armed;
   logic next_finished_latched;
   logic next_mon_status;
   logic start_pulse;
   logic stop_pulse;
   logic mon_pulse;

   // ************************************************************
   // insertion state
   // ************************************************************
   thep_pkg::thep_state_t state;
   thep_pkg::thep_state_t next_state;
   logic [7:0] errored_sent;
   logic [7:0] next_errored_sent;
   logic next_finished;
   logic next_tx_pkt_errored;
   logic rate_hit;
   logic [`THEP_PERIOD_W-1:0] period;

   // ************************************************************
   // bus state
   // ************************************************************
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic [9:0] idx;
   logic access;
   logic wr_done;
   logic mapped;
   logic [7:0] rd_byte;
   logic next_irq;
   logic [`THEP_PKT_CNT_W-1:0] pkt_shown;
   logic [`THEP_BYTE_CNT_W-1:0] byte_shown;

   assign idx = paddr[11:2];
   assign access = psel && penable;
   // a write takes effect at the edge where pready is seen high
   assign wr_done = access && pready && pwrite;

   // ************************************************************
   // rate period: x times ten to the y, y clamped at six
   // ************************************************************
   function automatic logic [`THEP_PERIOD_W-1:0] decade(input logic [2:0] y);
      logic [`THEP_PERIOD_W-1:0] d;
      d = '0;
      case (y)
         3'h0: d = 24'h000001;
         3'h1: d = 24'h00000a;
         3'h2: d = 24'h000064;
         3'h3: d = 24'h0003e8;
         3'h4: d = 24'h002710;
         3'h5: d = 24'h0186a0;
         default: d = 24'h0f4240;
      endcase
      return d;
   endfunction

   always_comb
   begin
      period = decade(rate_ctrl[6:4]) * {20'h00000, rate_ctrl[3:0]};
   end

   // ************************************************************
   // register writes
   // ************************************************************
   always_comb
   begin
      next_ctrl_low = ctrl_low;
      next_count_ctrl = count_ctrl;
      next_rate_ctrl = rate_ctrl;
      next_irq_enable = irq_enable;
      next_mon_update = mon_update;
      next_initiate_armed = initiate_armed;
      start_pulse = 1'b0;
      stop_pulse = 1'b0;
      if (wr_done)
      begin
         case (idx)
            `THEP_IDX_CTRL_LOW:
            begin
               next_ctrl_low = pwdata[7:0] & `THEP_CTRL_LOW_MASK;
               next_initiate_armed = pwdata[`THEP_BIT_INITIATE];
               start_pulse = pwdata[`THEP_BIT_INITIATE];
               stop_pulse = !pwdata[`THEP_BIT_INITIATE];
            end
            `THEP_IDX_COUNT_CTRL: next_count_ctrl = pwdata[7:0];
            `THEP_IDX_RATE_CTRL: next_rate_ctrl = pwdata[7:0];
            `THEP_IDX_IRQ_ENABLE: next_irq_enable = {7'h00, pwdata[`THEP_BIT_IRQ_EN]};
            `THEP_IDX_MON_UPDATE: next_mon_update = {7'h00, pwdata[`THEP_BIT_MON_UPDATE]};
            default: next_ctrl_low = ctrl_low;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ctrl_low <= `THEP_RST_BYTE;
         count_ctrl <= `THEP_RST_BYTE;
         rate_ctrl <= `THEP_RST_BYTE;
         irq_enable <= `THEP_RST_BYTE;
         mon_update <= `THEP_RST_BYTE;
         initiate_armed <= 1'b0;
      end
      else
      begin
         ctrl_low <= next_ctrl_low;
         count_ctrl <= next_count_ctrl;
         rate_ctrl <= next_rate_ctrl;
         irq_enable <= next_irq_enable;
         mon_update <= next_mon_update;
         initiate_armed <= next_initiate_armed;
      end
   end

   // ************************************************************
   // insertion sequencer
   // ************************************************************
   thep_rate_divider u_rate (
      .clk(clk),
      .rst_n(rst_n),
      .clear(start_pulse || state != thep_pkg::THEP_RUN),
      .step(tx_pkt_start && state == thep_pkg::THEP_RUN),
      .period(period),
      .hit(rate_hit)
   );

   always_comb
   begin
      next_state = state;
      next_errored_sent = errored_sent;
      next_finished = finished;
      next_tx_pkt_errored = 1'b0;
      case (state)
         thep_pkg::THEP_IDLE:
         begin
            if (start_pulse)
            begin
               next_state = thep_pkg::THEP_RUN;
               next_errored_sent = 8'h00;
               next_finished = 1'b0;
            end
         end
         thep_pkg::THEP_RUN:
         begin
            if (stop_pulse)
            begin
               next_state = thep_pkg::THEP_IDLE;
               next_finished = 1'b0;
            end
            else if (start_pulse)
            begin
               next_errored_sent = 8'h00;
               next_finished = 1'b0;
            end
            else if (count_ctrl != `THEP_TOTAL_CONTINUOUS && errored_sent == count_ctrl)
            begin
               next_state = thep_pkg::THEP_DONE;
               next_finished = 1'b1;
            end
            else if (rate_hit)
            begin
               next_tx_pkt_errored = 1'b1;
               if (count_ctrl != `THEP_TOTAL_CONTINUOUS)
                  next_errored_sent = errored_sent + 8'h01;
            end
         end
         thep_pkg::THEP_DONE:
         begin
            if (stop_pulse)
            begin
               next_state = thep_pkg::THEP_IDLE;
               next_finished = 1'b0;
            end
            else if (start_pulse)
            begin
               next_state = thep_pkg::THEP_RUN;
               next_errored_sent = 8'h00;
               next_finished = 1'b0;
            end
         end
         default:
         begin
            next_state = thep_pkg::THEP_IDLE;
            next_finished = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state <= thep_pkg::THEP_IDLE;
         errored_sent <= 8'h00;
         finished <= 1'b0;
         tx_pkt_errored <= 1'b0;
      end
      else
      begin
         state <= next_state;
         errored_sent <= next_errored_sent;
         finished <= next_finished;
         tx_pkt_errored <= next_tx_pkt_errored;
      end
   end

   // ************************************************************
   // latched flag, interrupt and monitoring update
   // ************************************************************
   assign mon_pulse = mon_update[`THEP_BIT_MON_UPDATE] && !mon_update_prev;

   always_comb
   begin
      next_finished_latched = finished_latched;
      // write one clears; a rising edge in the same cycle wins
      if (wr_done && idx == `THEP_IDX_STATUS_LATCHED && pwdata[`THEP_BIT_FINISHED])
         next_finished_latched = 1'b0;
      if (finished && !finished_prev)
         next_finished_latched = 1'b1;
      next_irq = next_finished_latched && irq_enable[`THEP_BIT_IRQ_EN];
      next_mon_status = mon_status;
      if (!mon_update[`THEP_BIT_MON_UPDATE])
         next_mon_status = 1'b0;
      else if (mon_pulse)
         next_mon_status = 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         finished_latched <= 1'b0;
         finished_prev <= 1'b0;
         irq <= 1'b0;
         mon_status <= 1'b0;
         mon_update_prev <= 1'b0;
      end
      else
      begin
         finished_latched <= next_finished_latched;
         finished_prev <= finished;
         irq <= next_irq;
         mon_status <= next_mon_status;
         mon_update_prev <= mon_update[`THEP_BIT_MON_UPDATE];
      end
   end

   // ************************************************************
   // performance counters
   // ************************************************************
   thep_pm_counter #(.W(`THEP_PKT_CNT_W)) u_pkt_cnt (
      .clk(clk),
      .rst_n(rst_n),
      .inc(tx_pkt_start),
      .update(mon_pulse),
      .shown(pkt_shown)
   );

   thep_pm_counter #(.W(`THEP_BYTE_CNT_W)) u_byte_cnt (
      .clk(clk),
      .rst_n(rst_n),
      .inc(tx_byte_sent),
      .update(mon_pulse),
      .shown(byte_shown)
   );

   // ************************************************************
   // apb read and answer, one wait state so outputs come from flops
   // ************************************************************
   always_comb
   begin
      mapped = 1'b1;
      rd_byte = 8'h00;
      case (idx)
         `THEP_IDX_CTRL_LOW: rd_byte = ctrl_low;
         `THEP_IDX_COUNT_CTRL: rd_byte = count_ctrl;
         `THEP_IDX_RATE_CTRL: rd_byte = rate_ctrl & `THEP_RATE_MASK;
         `THEP_IDX_STATUS: rd_byte = {7'h00, finished};
         `THEP_IDX_STATUS_LATCHED: rd_byte = {7'h00, finished_latched};
         `THEP_IDX_IRQ_ENABLE: rd_byte = irq_enable;
         `THEP_IDX_PKT_CNT0: rd_byte = pkt_shown[7:0];
         `THEP_IDX_PKT_CNT1: rd_byte = pkt_shown[15:8];
         `THEP_IDX_PKT_CNT2: rd_byte = pkt_shown[23:16];
         `THEP_IDX_BYTE_CNT0: rd_byte = byte_shown[7:0];
         `THEP_IDX_BYTE_CNT1: rd_byte = byte_shown[15:8];
         `THEP_IDX_BYTE_CNT2: rd_byte = byte_shown[23:16];
         `THEP_IDX_BYTE_CNT3: rd_byte = byte_shown[31:24];
         `THEP_IDX_MON_UPDATE: rd_byte = mon_update;
         `THEP_IDX_MON_STATUS: rd_byte = {7'h00, mon_status};
         default: mapped = 1'b0;
      endcase
      next_pready = access && !pready;
      next_pslverr = access && !pready && !mapped;
      next_prdata = prdata;
      if (access && !pready)
         next_prdata = (pwrite || !mapped) ? 32'h00000000 : {24'h000000, rd_byte};
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

endmodule // thep_top

// ===== dv/thep_top_monitor.sv
// concurrent checks on the ports of the errored-packet insertion block
`timescale 1ns/100ps
`include "thep_cfg.svh"

module thep_top_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // transmit datapath and interrupt
   input wire logic tx_pkt_start,
   input wire logic tx_byte_sent,
   input wire logic tx_pkt_errored,
   input wire logic irq
);
   // ************************************************************
   // helpers
   // ************************************************************
   logic [9:0] idx;
   logic mapped;
   logic irq_touch;
   assign idx = paddr[11:2];
   assign mapped = idx inside {10'h0c4, [10'h0c6:10'h0ca], [10'h0cc:10'h0ce],
      [10'h0d0:10'h0d3], 10'h0d6, 10'h0d7};
   // a write to latch or enable may drop irq up to a cycle after it lands
   assign irq_touch = psel && pwrite &&
      (idx == `THEP_IDX_STATUS_LATCHED || idx == `THEP_IDX_IRQ_ENABLE);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_setup_access;
      psel && !penable ##1 psel && penable;
   endsequence

   // ************************************************************
   // assertions
   // ************************************************************
   AST_READY_AFTER_SETUP: assert property (s_setup_access |=> pready)
      else $error("pready late after access phase");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   AST_UNMAPPED_ERR: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr wrong for address");
   AST_UNMAPPED_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   AST_INITIATE_WO: assert property (pready && !pwrite && idx == `THEP_IDX_CTRL_LOW
      |-> !prdata[0])
      else $error("initiate bit readable");
   AST_PRDATA_HOLD: assert property ($changed(prdata) |-> pready)
      else $error("prdata changed outside a transfer");
   AST_ERR_FOLLOWS_PKT: assert property (tx_pkt_errored |-> $past(tx_pkt_start))
      else $error("errored mark without packet");
   AST_IRQ_HOLDS: assert property (irq && !irq_touch && !$past(irq_touch) |=> irq)
      else $error("irq dropped without software");
endmodule // thep_top_monitor

bind thep_top thep_top_monitor i_monitor (.clk(clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .tx_pkt_start(tx_pkt_start),
   .tx_byte_sent(tx_byte_sent), .tx_pkt_errored(tx_pkt_errored), .irq(irq));

// ===== dv/tb_thep_top.sv
// self-checking bench for the errored-packet insertion and counter block
`timescale 1ns/100ps
`include "thep_cfg.svh"

module tb_thep_top;
   logic clk;
   logic rst_n;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic tx_pkt_start;
   logic tx_byte_sent;
   logic tx_pkt_errored;
   logic irq;
   int failures = 0;
   int samples_checked = 0;

   thep_top i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_pkt_start(tx_pkt_start), .tx_byte_sent(tx_byte_sent),
      .tx_pkt_errored(tx_pkt_errored), .irq(irq));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one apb transfer, entered and left just after a rising edge
   task automatic acc(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
      input logic [7:0] exp, input logic exp_err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      // no cycle count assumed here: only the watchdog ends a hung transfer
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      chk("pready", {31'h0, pready}, 32'h1);
      chk("pslverr", {31'h0, pslverr}, {31'h0, exp_err});
      if (!wr)
         chk("prdata", prdata, {24'h0, exp});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      acc(1'b1, idx, d, 8'h00, 1'b0);
   endtask

   task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
      acc(1'b0, idx, 8'h00, exp, 1'b0);
   endtask

   // one packet of one byte; the mark is due in the cycle after the start pulse
   task automatic pkt(input logic exp_err);
      tx_pkt_start <= 1'b1;
      tx_byte_sent <= 1'b1;
      @(posedge clk);
      tx_pkt_start <= 1'b0;
      tx_byte_sent <= 1'b0;
      @(posedge clk);
      chk("tx_pkt_errored", {31'h0, tx_pkt_errored}, {31'h0, exp_err});
   endtask

   task automatic run(input logic [7:0] total, input logic [7:0] rate);
      wr(`THEP_IDX_COUNT_CTRL, total);
      wr(`THEP_IDX_RATE_CTRL, rate);
      wr(`THEP_IDX_CTRL_LOW, 8'h01);
   endtask

   task automatic cleanup();
      wr(`THEP_IDX_COUNT_CTRL, 8'h00);
      wr(`THEP_IDX_RATE_CTRL, 8'h00);
      wr(`THEP_IDX_CTRL_LOW, 8'h00);
   endtask

   task automatic chk_irq(input logic exp);
      repeat (2) @(posedge clk);
      chk("irq", {31'h0, irq}, {31'h0, exp});
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      finish_test();
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      tx_pkt_start = 1'b0;
      tx_byte_sent = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // reset values, access kinds and an unmapped place
      rd(`THEP_IDX_STATUS, 8'h00);
      rd(`THEP_IDX_IRQ_ENABLE, 8'h00);
      for (int k = 0; k < 3; k++)
         rd(10'(`THEP_IDX_PKT_CNT0 + k), 8'h00);
      for (int k = 0; k < 4; k++)
         rd(10'(`THEP_IDX_BYTE_CNT0 + k), 8'h00);
      acc(1'b1, 10'h0c5, 8'h5a, 8'h00, 1'b1);
      acc(1'b0, 10'h0c5, 8'h00, 8'h00, 1'b1);
      wr(`THEP_IDX_STATUS, 8'hff);
      rd(`THEP_IDX_STATUS, 8'h00);
      wr(`THEP_IDX_IRQ_ENABLE, 8'hff);
      rd(`THEP_IDX_IRQ_ENABLE, 8'h01);
      // three errored packets in a row, then nothing more
      run(8'h03, 8'h01);
      rd(`THEP_IDX_CTRL_LOW, 8'h00);
      repeat (3) pkt(1'b1);
      pkt(1'b0);
      rd(`THEP_IDX_STATUS, 8'h01);
      rd(`THEP_IDX_STATUS_LATCHED, 8'h01);
      chk_irq(1'b1);
      wr(`THEP_IDX_IRQ_ENABLE, 8'h00);
      chk_irq(1'b0);
      wr(`THEP_IDX_IRQ_ENABLE, 8'h01);
      chk_irq(1'b1);
      cleanup();
      rd(`THEP_IDX_STATUS, 8'h00);
      rd(`THEP_IDX_STATUS_LATCHED, 8'h01);
      wr(`THEP_IDX_STATUS_LATCHED, 8'h01);
      rd(`THEP_IDX_STATUS_LATCHED, 8'h00);
      chk_irq(1'b0);
      // x = 3, y = 1: every thirtieth packet, two of them
      run(8'h02, 8'h13);
      for (int i = 1; i <= 60; i++)
         pkt(i % 30 == 0);
      chk_irq(1'b1);
      rd(`THEP_IDX_STATUS, 8'h01);
      rd(`THEP_IDX_STATUS_LATCHED, 8'h01);
      wr(`THEP_IDX_CTRL_LOW, 8'h01);
      rd(`THEP_IDX_STATUS, 8'h00);
      cleanup();
      // x = 0 never marks; continuous mode never finishes
      run(8'h01, 8'h20);
      repeat (5) pkt(1'b0);
      rd(`THEP_IDX_STATUS, 8'h00);
      cleanup();
      run(8'hff, 8'h02);
      for (int i = 1; i <= 10; i++)
         pkt(i % 2 == 0);
      rd(`THEP_IDX_STATUS, 8'h00);
      cleanup();
      // counters: restart, count, snapshot, restart again
      wr(`THEP_IDX_MON_UPDATE, 8'h01);
      rd(`THEP_IDX_MON_STATUS, 8'h01);
      wr(`THEP_IDX_MON_UPDATE, 8'h00);
      rd(`THEP_IDX_MON_STATUS, 8'h00);
      repeat (260) pkt(1'b0);
      tx_byte_sent <= 1'b1;
      repeat (40) @(posedge clk);
      tx_byte_sent <= 1'b0;
      @(posedge clk);
      wr(`THEP_IDX_MON_UPDATE, 8'h01);
      for (int k = 0; k < 3; k++)
         rd(10'(`THEP_IDX_PKT_CNT0 + k), 8'(24'h000104 >> (8 * k)));
      for (int k = 0; k < 4; k++)
         rd(10'(`THEP_IDX_BYTE_CNT0 + k), 8'(32'h0000012c >> (8 * k)));
      wr(`THEP_IDX_MON_UPDATE, 8'h00);
      wr(`THEP_IDX_MON_UPDATE, 8'h01);
      rd(`THEP_IDX_PKT_CNT0, 8'h00);
      rd(`THEP_IDX_BYTE_CNT1, 8'h00);
      finish_test();
   end
endmodule // tb_thep_top
